// >>> rtl/rom_data_window.sv
/*
 Return-address stack and read-only data window of the core data space.
 Assumes the core holds a read request until it sees the answer strobe, gives writes
 for one cycle, and that program memory answers a fetch some cycles later.
*/
// Operation
// - A six-entry 12-bit return stack saves the program counter on call or interrupt and restores it on return.
// - Reads at data addresses 40h to 7Fh return program-memory bytes instead of RAM.
// - The window can sit anywhere in program memory up to 0FFFh in 64-byte steps.
// - The fetch address is the window base above the low six data address bits.
// - The window base register sits at C9h and takes ordinary byte writes.
// - Reset leaves the window base register unchanged.
// - Base bits 5 to 0 select the window and bits 6 and 7 do nothing.
// - Addresses 00h to 3Fh form a banked region for one RAM and up to two EEPROM banks.
`timescale 1ns/1ps
`default_nettype none
module rom_data_window #(
	parameter int EE_BANKS = 2
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// Core data-space access
	input wire logic data_rd_in,
	input wire logic data_wr_in,
	input wire logic [rom_data_window_pkg::DATA_AW-1:0] data_addr_in,
	input wire logic [7:0] data_wdata_in,
	output logic data_ack_out,
	output logic [7:0] data_rdata_out,
	output logic window_hit_out,
	// Bank select for the low region
	input wire logic bank_sel_wr_in,
	input wire logic [7:0] bank_sel_in,
	output logic [1:0] bank_region_out,
	// Program memory fetch port
	output logic prog_rd_out,
	output logic [rom_data_window_pkg::PROG_AW-1:0] prog_addr_out,
	input wire logic prog_valid_in,
	input wire logic [7:0] prog_data_in,
	// Return stack
	input wire logic push_in,
	input wire logic pop_in,
	input wire logic [rom_data_window_pkg::PROG_AW-1:0] pc_in,
	output logic [rom_data_window_pkg::PROG_AW-1:0] ret_pc_out,
	output logic [2:0] stack_level_out
);
	import rom_data_window_pkg::*;

	// Only zero to two EEPROM banks can be switched in
	if (EE_BANKS < 0 || EE_BANKS > 2) begin : g_bad_ee_banks
		$error("EE_BANKS must be 0 to 2");
	end

	logic [7:0] rom_window_base;
	logic [PROG_AW-1:0] stack_mem [STACK_DEPTH];
	logic [2:0] level_reg;
	win_state_t state_reg;
	logic [1:0] bank_reg;
	logic in_window;
	logic [PROG_AW-1:0] fetch_addr;

	// Fetch address: base select bits above the low data address bits
	assign in_window = (data_addr_in >= WIN_FIRST_ADDR) && (data_addr_in <= WIN_LAST_ADDR);
	assign fetch_addr = {rom_window_base[WIN_SEL_BITS-1:0], data_addr_in[WIN_LOW_BITS-1:0]};

	// Base register: no reset term, so reset leaves it as it was
	always_ff @(posedge clk_in) begin
		if (data_wr_in && data_addr_in == ROM_WINDOW_BASE_ADDR)
			rom_window_base <= data_wdata_in;
	end

	// Window read sequencer
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			state_reg <= ST_IDLE;
			prog_rd_out <= 1'b0;
			prog_addr_out <= '0;
			data_ack_out <= 1'b0;
			data_rdata_out <= '0;
			window_hit_out <= 1'b0;
		end else begin
			data_ack_out <= 1'b0;
			case (state_reg)
			ST_IDLE: begin
				if (data_rd_in && in_window) begin
					prog_rd_out <= 1'b1;
					prog_addr_out <= fetch_addr;
					window_hit_out <= 1'b1;
					state_reg <= ST_FETCH;
				end else if (data_rd_in && data_addr_in == ROM_WINDOW_BASE_ADDR) begin
					data_rdata_out <= UNDEF_READ_VALUE;
					data_ack_out <= 1'b1;
					window_hit_out <= 1'b0;
				end else begin
					window_hit_out <= 1'b0;
				end
			end
			ST_FETCH: begin
				if (prog_valid_in) begin
					prog_rd_out <= 1'b0;
					data_rdata_out <= prog_data_in;
					data_ack_out <= 1'b1;
					state_reg <= ST_DONE;
				end
			end
			ST_DONE: begin
				window_hit_out <= 1'b0;
				state_reg <= ST_IDLE;
			end
			default: state_reg <= ST_IDLE;
			endcase
		end
	end

	// Banked low region selection
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			bank_reg <= BANK_MAIN;
		end else if (bank_sel_wr_in) begin
			if (bank_sel_in == BANK_SEL_RAM2)
				bank_reg <= BANK_RAM2;
			else if (bank_sel_in == BANK_SEL_EE0 && EE_BANKS >= 1)
				bank_reg <= BANK_EE0;
			else if (bank_sel_in == BANK_SEL_EE1 && EE_BANKS >= 2)
				bank_reg <= BANK_EE1;
			else
				bank_reg <= BANK_MAIN;
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in)
			bank_region_out <= BANK_MAIN;
		else if (data_addr_in <= BANK_LAST_ADDR && data_addr_in >= BANK_FIRST_ADDR)
			bank_region_out <= bank_reg;
		else
			bank_region_out <= BANK_MAIN;
	end

	// Return stack: push shifts down, pop shifts up
	genvar gi;
	generate
		for (gi = 0; gi < STACK_DEPTH; gi++) begin : g_stack
			always_ff @(posedge clk_in) begin
				if (rst_in)
					stack_mem[gi] <= '0;
				else if (push_in)
					stack_mem[gi] <= (gi == 0) ? pc_in : stack_mem[(gi == 0) ? 0 : gi-1];
				else if (pop_in)
					stack_mem[gi] <= (gi == STACK_DEPTH-1) ? '0 : stack_mem[(gi == STACK_DEPTH-1) ? gi : gi+1];
			end
		end
	endgenerate

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			level_reg <= '0;
			ret_pc_out <= '0;
		end else if (push_in) begin
			if (level_reg != 3'(STACK_DEPTH))
				level_reg <= level_reg + 3'h1;
			ret_pc_out <= pc_in;
		end else if (pop_in) begin
			if (level_reg != 3'h0)
				level_reg <= level_reg - 3'h1;
			ret_pc_out <= stack_mem[1];
		end
	end
	assign stack_level_out = level_reg;

	// Base register checks run through reset, since the base has no reset term
	base_write_a: assert property (@(posedge clk_in)
		(data_wr_in && data_addr_in == ROM_WINDOW_BASE_ADDR) |=> rom_window_base == $past(data_wdata_in))
		else $error("base not loaded");
	base_read_a: assert property (@(posedge clk_in)
		(data_rd_in && !data_wr_in) |=> rom_window_base === $past(rom_window_base))
		else $error("base disturbed by read");
	base_reset_a: assert property (@(posedge clk_in)
		(rst_in && !data_wr_in) |=> rom_window_base === $past(rom_window_base))
		else $error("base changed by reset");
	win_fetch_a: assert property (@(posedge clk_in) disable iff (rst_in)
		(state_reg == ST_IDLE && data_rd_in && in_window) |=> prog_rd_out && prog_addr_out == $past(fetch_addr))
		else $error("window fetch wrong");
	fetch_addr_a: assert property (@(posedge clk_in) disable iff (rst_in)
		prog_rd_out && $rose(prog_rd_out) |-> prog_addr_out[WIN_LOW_BITS-1:0] == $past(data_addr_in[WIN_LOW_BITS-1:0]))
		else $error("low bits wrong");
	fetch_data_a: assert property (@(posedge clk_in) disable iff (rst_in)
		(state_reg == ST_FETCH && prog_valid_in) |=> data_ack_out && data_rdata_out == $past(prog_data_in))
		else $error("window data wrong");
	stack_push_a: assert property (@(posedge clk_in) disable iff (rst_in)
		push_in |=> stack_mem[0] == $past(pc_in))
		else $error("push lost");
	stack_pop_a: assert property (@(posedge clk_in) disable iff (rst_in)
		(pop_in && !push_in) |=> ret_pc_out == $past(stack_mem[1]))
		else $error("pop wrong");
	bank_out_a: assert property (@(posedge clk_in) disable iff (rst_in)
		(data_addr_in > BANK_LAST_ADDR) |=> bank_region_out == BANK_MAIN)
		else $error("bank outside region");
	hit_fetch_a: assert property (@(posedge clk_in) disable iff (rst_in)
		prog_rd_out |-> window_hit_out)
		else $error("fetch without window hit");
	no_fetch_a: assert property (@(posedge clk_in) disable iff (rst_in)
		(state_reg == ST_IDLE && !(data_rd_in && in_window)) |=> !prog_rd_out)
		else $error("fetch outside window");
	fetch_hold_a: assert property (@(posedge clk_in) disable iff (rst_in)
		(state_reg == ST_FETCH && !prog_valid_in) |=> prog_rd_out && $stable(prog_addr_out))
		else $error("fetch not held");
	base_undef_a: assert property (@(posedge clk_in) disable iff (rst_in)
		(state_reg == ST_IDLE && data_rd_in && data_addr_in == ROM_WINDOW_BASE_ADDR) |=> data_ack_out && data_rdata_out == UNDEF_READ_VALUE)
		else $error("base read answer wrong");
	stack_shift_a: assert property (@(posedge clk_in) disable iff (rst_in)
		(pop_in && !push_in) |=> stack_mem[0] == $past(stack_mem[1]))
		else $error("pop shift wrong");
	level_bound_a: assert property (@(posedge clk_in) disable iff (rst_in)
		level_reg <= 3'(STACK_DEPTH))
		else $error("stack level too high");
	bank_in_a: assert property (@(posedge clk_in) disable iff (rst_in)
		(data_addr_in <= BANK_LAST_ADDR) |=> bank_region_out == $past(bank_reg))
		else $error("bank inside region wrong");
endmodule
`default_nettype wire

// >>> rtl/rom_data_window_pkg.sv
/*
 Constants for the data-space window and return stack block.
 Assumes an 8-bit data space and a 12-bit program space.
*/
package rom_data_window_pkg;
	localparam int DATA_AW = 8;
	localparam int PROG_AW = 12;
	localparam int STACK_DEPTH = 6;
	localparam int WIN_LOW_BITS = 6;
	localparam int WIN_SEL_BITS = 6;
	localparam logic [7:0] ROM_WINDOW_BASE_ADDR = 8'hc9;
	localparam logic [7:0] WIN_FIRST_ADDR = 8'h40;
	localparam logic [7:0] WIN_LAST_ADDR = 8'h7f;
	localparam logic [7:0] BANK_FIRST_ADDR = 8'h00;
	localparam logic [7:0] BANK_LAST_ADDR = 8'h3f;
	localparam logic [7:0] UNDEF_READ_VALUE = 8'hff;
	localparam logic [1:0] BANK_MAIN = 2'h0;
	localparam logic [1:0] BANK_RAM2 = 2'h1;
	localparam logic [1:0] BANK_EE0 = 2'h2;
	localparam logic [1:0] BANK_EE1 = 2'h3;
	localparam logic [7:0] BANK_SEL_RAM2 = 8'h10;
	localparam logic [7:0] BANK_SEL_EE0 = 8'h01;
	localparam logic [7:0] BANK_SEL_EE1 = 8'h02;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_FETCH = 3'b010,
		ST_DONE = 3'b100
	} win_state_t;
endpackage

// >>> tb/prog_mem_model.sv
/*
 Program memory model answering window fetches.
 Assumes a fetch is held until answered; the answer comes after wait_in cycles.
*/
`timescale 1ns/1ps
`default_nettype none
module prog_mem_model (
	input wire logic clk_in,
	input wire logic prog_rd_in,
	input wire logic [11:0] prog_addr_in,
	input wire logic [3:0] wait_in,
	output logic prog_valid_out,
	output logic [7:0] prog_data_out
);
	logic [3:0] cnt_reg = 4'h0;
	logic served_reg = 1'b0;
	initial prog_valid_out = 1'b0;
	initial prog_data_out = 8'h5a;
	always @(posedge clk_in) begin
		prog_valid_out <= 1'b0;
		// Data outside the answer cycle keeps toggling so a late sample shows
		prog_data_out <= ~prog_data_out;
		if (!prog_rd_in) begin
			cnt_reg <= 4'h0;
			served_reg <= 1'b0;
		end else if (!served_reg && cnt_reg == wait_in) begin
			prog_valid_out <= 1'b1;
			prog_data_out <= prog_addr_in[7:0] ^ {prog_addr_in[3:0], prog_addr_in[11:8]};
			served_reg <= 1'b1;
		end else begin
			cnt_reg <= cnt_reg + 4'h1;
		end
	end
endmodule
`default_nettype wire

// >>> tb/tb_top.sv
/*
 Self-checking bench for the data window, base register, banks and return stack.
 Assumes the program memory model in prog_mem_model.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import rom_data_window_pkg::*;
	logic clk_in = 0, rst_in = 1, rd = 0, wr = 0, bank_wr = 0, push = 0, pop = 0;
	logic [7:0] addr = 0, wdata = 0, bank_sel = 0, rdata, prog_data;
	logic [11:0] pc = 0, ret_pc, prog_addr, seen_pa;
	logic [7:0] base_copy = 0;
	logic [3:0] wait_reg = 0;
	logic [2:0] level;
	logic [1:0] region;
	logic ack, hit, prog_rd, prog_valid, seen_hit;
	logic [31:0] seed = 32'h92cea6a2;
	int errors = 0, n_compared = 0;
	always #2.5 clk_in = ~clk_in;
	rom_data_window i_rom_data_window (.clk_in(clk_in), .rst_in(rst_in), .data_rd_in(rd), .data_wr_in(wr),
		.data_addr_in(addr), .data_wdata_in(wdata), .data_ack_out(ack), .data_rdata_out(rdata),
		.window_hit_out(hit), .bank_sel_wr_in(bank_wr), .bank_sel_in(bank_sel), .bank_region_out(region),
		.prog_rd_out(prog_rd), .prog_addr_out(prog_addr), .prog_valid_in(prog_valid), .prog_data_in(prog_data),
		.push_in(push), .pop_in(pop), .pc_in(pc), .ret_pc_out(ret_pc), .stack_level_out(level));
	prog_mem_model i_prog_mem_model (.clk_in(clk_in), .prog_rd_in(prog_rd), .prog_addr_in(prog_addr),
		.wait_in(wait_reg), .prog_valid_out(prog_valid), .prog_data_out(prog_data));
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// Byte that the program memory model holds at a given address
	function automatic logic [7:0] rom_byte(logic [11:0] pa);
		return pa[7:0] ^ {pa[3:0], pa[11:8]};
	endfunction
	task automatic chk(string what, logic [11:0] seen, logic [11:0] exp);
		n_compared++;
		if (seen !== exp) begin
			errors++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic print_verdict();
		$display("compared %0d errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task automatic access(logic [7:0] a);
		int i;
		repeat (2) @(negedge clk_in);
		rd = 1;
		addr = a;
		// Request stands until the answer strobe is seen
		for (i = 0; i < 40 && ack !== 1'b1; i++) begin
			@(negedge clk_in);
			if (i == 0) seen_hit = hit;
			if (prog_rd === 1'b1) seen_pa = prog_addr;
		end
		rd = 0;
		if (ack !== 1'b1) begin
			errors++;
			print_verdict();
		end
	endtask
	task automatic wr_base(logic [7:0] v);
		// Shadow copy first, as software keeps one of the write-only base
		base_copy = v;
		@(negedge clk_in);
		wr = 1;
		addr = ROM_WINDOW_BASE_ADDR;
		wdata = v;
		@(negedge clk_in);
		wr = 0;
	endtask
	task automatic win(logic [7:0] a, logic [7:0] base);
		logic [11:0] pa;
		pa = {base[5:0], a[5:0]};
		seen_pa = ~pa;
		access(a);
		chk("prog_addr", seen_pa, pa);
		chk("window_data", {4'h0, rdata}, {4'h0, rom_byte(pa)});
		chk("window_hit", {11'h0, seen_hit}, 12'h1);
	endtask
	logic [7:0] codes [5] = '{8'h00, 8'h01, 8'h02, 8'h08, 8'h10};
	logic [1:0] regions [5] = '{BANK_MAIN, BANK_EE0, BANK_EE1, BANK_MAIN, BANK_RAM2};
	initial begin
		int i;
		logic [31:0] b;
		repeat (12) @(negedge clk_in);
		rst_in = 0;
		wr_base(8'hc0);
		win(8'h40, 8'h00);
		wr_base(8'h3f);
		win(8'h7f, 8'h3f);
		access(ROM_WINDOW_BASE_ADDR);
		chk("base_read", {4'h0, rdata}, {4'h0, UNDEF_READ_VALUE});
		chk("base_hit", {11'h0, seen_hit}, 12'h0);
		// A read of plain RAM must not reach program memory
		@(negedge clk_in);
		rd = 1;
		addr = 8'h90;
		repeat (4) begin
			@(negedge clk_in);
			chk("ram_no_fetch", {10'h0, prog_rd, ack}, 12'h0);
		end
		rd = 0;
		win(8'h55, 8'h3f);
		rst_in = 1;
		repeat (2) @(negedge clk_in);
		rst_in = 0;
		win(8'h41, base_copy);
		for (i = 0; i < 20; i++) begin
			b = rnd();
			wait_reg = b[11:8];
			wr_base(b[7:0]);
			win({2'b01, b[21:16]}, b[7:0]);
		end
		for (i = 0; i < 5; i++) begin
			@(negedge clk_in);
			bank_wr = 1;
			bank_sel = codes[i];
			addr = 8'h20;
			@(negedge clk_in);
			bank_wr = 0;
			@(negedge clk_in);
			chk("bank_region", {10'h0, region}, {10'h0, regions[i]});
		end
		for (i = 1; i <= 7; i++) begin
			@(negedge clk_in);
			push = 1;
			pc = 12'(i * 12'h111);
			@(negedge clk_in);
			push = 0;
			chk("push_pc", ret_pc, 12'(i * 12'h111));
		end
		chk("level_full", {9'h0, level}, 12'h6);
		for (i = 6; i >= 2; i--) begin
			@(negedge clk_in);
			pop = 1;
			@(negedge clk_in);
			pop = 0;
			chk("pop_pc", ret_pc, 12'(i * 12'h111));
		end
		chk("level_low", {9'h0, level}, 12'h1);
		print_verdict();
	end
endmodule
`default_nettype wire
